// File: hw/rts_pkg.sv
// Shared timing constants for the receipt timestamp and range block.
package rts_pkg;

  // Local clock.
  localparam int CLK_PERIOD_NS = 4;

  // Receipt timestamp step and the cycles per step.
  localparam int STAMP_STEP_NS = 100;
  localparam int STAMP_CYC     = STAMP_STEP_NS / CLK_PERIOD_NS;

  // Message start slot period.
  localparam int MSO_PERIOD_US = 250;
  localparam int MSO_CYC       = (MSO_PERIOD_US * 1000) / CLK_PERIOD_NS;

  // One UTC second.
  localparam int SEC_NS  = 1_000_000_000;
  localparam int SEC_CYC = SEC_NS / CLK_PERIOD_NS;

  // Alignment and stamping error budgets; the design must stay well inside them.
  localparam int TX_ALIGN_ERR_NS = 500;
  localparam int TX_ALIGN_CYC    = TX_ALIGN_ERR_NS / CLK_PERIOD_NS;
  localparam int STAMP_ERR_NS    = 500;
  localparam int STAMP_ERR_CYC   = STAMP_ERR_NS / CLK_PERIOD_NS;

  // Grace time after a missing second pulse before coupling is dropped.
  localparam int PULSE_LATE_NS  = 1000;
  localparam int PULSE_LATE_CYC = PULSE_LATE_NS / CLK_PERIOD_NS;

  // Cycles from the time pulse pin to the counter restart (two sync stages plus edge).
  localparam int PULSE_PATH_CYC = 3;

  // Range tracking machine.
  typedef enum logic [0:0] {
    RTS_RANGE_IDLE,
    RTS_RANGE_LOOK
  } rts_range_state_e;

endpackage : rts_pkg

// File: hw/rts_mem.sv
// Per-target store of the integer slot count, registered read.
`timescale 1ns/1ps
module rts_mem #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input  wire logic                     clk_in,
  input  wire logic                     rst_b_in,
  input  wire logic                     wr_en_in,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr_in,
  input  wire logic [WIDTH-1:0]         wr_data_in,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr_in,
  output logic      [WIDTH-1:0]         rd_data_out
);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] rd_data_d;

  always_comb
  begin
    rd_data_d = mem_q[rd_addr_in];
  end

  always_ff @(posedge clk_in)
  begin
    if (wr_en_in)
    begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
    if (!rst_b_in)
    begin
      rd_data_out <= '0;
    end
    else
    begin
      rd_data_out <= rd_data_d;
    end
  end

endmodule : rts_mem

// File: hw/rts_top.sv
// Time base, slot-aligned transmit start, receipt stamping and per-target range.
// How it works
// - utc_coupled_out always tells the transmit path whether time is UTC coupled.
// - Transmit start fires on the very edge a message start slot begins.
// - Receipt stamp is latched from the disciplined counter, truncated to whole 100 ns (25 cycle) steps.
// - External second pulse, or internal one, restarts the whole time base.
// - Receipt stamp counts 100 ns steps from the start of the UTC second.
// - Range is whole 250 us slots plus the fraction of one slot.
// - Fraction is recomputed from each state vector report.
// - Integer count becomes valid only after a long type 1 report.
// - Epoch field gives the transmit slot; integer is receipt slot minus it.
// - Between epoch reports the stored integer is reused with fresh fractions.
`timescale 1ns/1ps
module rts_top #(
  parameter int SEC_CYC  = rts_pkg::SEC_CYC,
  parameter int MSO_CYC  = rts_pkg::MSO_CYC,
  parameter int TARGETS  = 16,
  localparam int TGTW    = $clog2(TARGETS),
  localparam int TPS     = SEC_CYC / rts_pkg::STAMP_CYC,
  localparam int TPM     = MSO_CYC / rts_pkg::STAMP_CYC,
  localparam int MPS     = SEC_CYC / MSO_CYC,
  localparam int STW     = $clog2(TPS),
  localparam int FRW     = $clog2(TPM),
  localparam int IDXW    = $clog2(MPS),
  localparam int SECW    = $clog2(SEC_CYC + rts_pkg::PULSE_LATE_CYC + 1)
) (
  input  wire logic            clk_in,
  input  wire logic            rst_b_in,
  input  wire logic            second_pulse_in,
  input  wire logic            internal_pulse_in,
  input  wire logic            time_source_ext_in,
  input  wire logic            utc_lock_in,
  input  wire logic            tx_request_in,
  input  wire logic            rx_sync_in,
  input  wire logic            rpt_valid_in,
  input  wire logic [TGTW-1:0] rpt_target_in,
  input  wire logic            rpt_long_type1_in,
  input  wire logic [IDXW-1:0] rpt_epoch_in,
  input  wire logic            rpt_remote_coupled_in,
  output logic                 utc_coupled_out,
  output logic                 tx_start_out,
  output logic      [STW-1:0]  receipt_time_stamp_out,
  output logic      [IDXW-1:0] receipt_slot_out,
  output logic                 stamp_valid_out,
  output logic                 range_strobe_out,
  output logic                 range_ok_out,
  output logic      [TGTW-1:0] range_target_out,
  output logic      [IDXW-1:0] range_int_out,
  output logic      [FRW-1:0]  range_frac_out
);

  initial
  begin
    if (SEC_CYC % MSO_CYC != 0 || MSO_CYC % rts_pkg::STAMP_CYC != 0 || TARGETS < 2
        || (2 ** TGTW) != TARGETS)
    begin
      $error("rts_top: second must hold whole slots, slot whole stamp steps");
    end
  end

  // Pin synchronisers: stage one is read only by stage two.
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic       pulse_prev_q;

  // Time base.
  logic [$clog2(rts_pkg::STAMP_CYC)-1:0] tick_q, tick_d;
  logic [STW-1:0]  stamp_q, stamp_d;
  logic [FRW-1:0]  mso_tick_q, mso_tick_d;
  logic [$clog2(MSO_CYC)-1:0] mso_cyc_q, mso_cyc_d;
  logic [IDXW-1:0] mso_idx_q, mso_idx_d;
  logic [SECW-1:0] since_q, since_d;
  logic            coupled_q, coupled_d;
  logic            pend_q, pend_d;
  logic            tx_start_d;
  logic            pulse_sel;
  logic            pulse_edge;
  logic            boundary;

  // Receipt capture.
  logic [STW-1:0]  stamp_out_d;
  logic [IDXW-1:0] rx_slot_d;
  logic [FRW-1:0]  rx_frac_q, rx_frac_d;
  logic            rx_coupled_q, rx_coupled_d;
  logic            stamp_valid_d;

  // Range tracking.
  rts_pkg::rts_range_state_e st_q, st_d;
  logic [TARGETS-1:0] tvalid_q, tvalid_d;
  logic [TGTW-1:0] tgt_q, tgt_d;
  logic            type1_q, type1_d;
  logic [IDXW-1:0] epoch_q, epoch_d;
  logic            remote_q, remote_d;
  logic            range_strobe_d;
  logic            range_ok_d;
  logic [IDXW-1:0] range_int_d;
  logic [FRW-1:0]  range_frac_d;
  logic            wr_en;
  logic [IDXW-1:0] int_calc;
  logic [IDXW:0]   int_wide;
  logic [IDXW-1:0] mem_rd;
  logic            pair_ok;

  rts_mem #(
    .WIDTH (IDXW),
    .DEPTH (TARGETS)
  ) u_mem (
    .clk_in      (clk_in),
    .rst_b_in    (rst_b_in),
    .wr_en_in    (wr_en),
    .wr_addr_in  (tgt_q),
    .wr_data_in  (int_calc),
    .rd_addr_in  (rpt_target_in),
    .rd_data_out (mem_rd)
  );

  always_comb
  begin
    pulse_sel  = time_source_ext_in ? sync2_q[0] : sync2_q[1];
    // Selection sits after the synchronisers, so switching sources can fake one edge.
    pulse_edge = pulse_sel && !pulse_prev_q;
    boundary   = pulse_edge || (mso_cyc_q == ($bits(mso_cyc_q))'(MSO_CYC - 1));

    tick_d     = tick_q;
    stamp_d    = stamp_q;
    mso_tick_d = mso_tick_q;
    mso_cyc_d  = mso_cyc_q;
    mso_idx_d  = mso_idx_q;
    if (pulse_edge)
    begin
      // Restart on the second; the pin path costs a fixed 12 ns, far inside budget.
      tick_d     = '0;
      stamp_d    = '0;
      mso_tick_d = '0;
      mso_cyc_d  = '0;
      mso_idx_d  = '0;
    end
    else
    begin
      if (tick_q == ($bits(tick_q))'(rts_pkg::STAMP_CYC - 1))
      begin
        tick_d     = '0;
        stamp_d    = (stamp_q == STW'(TPS - 1)) ? '0 : stamp_q + 1'b1;
        mso_tick_d = (mso_tick_q == FRW'(TPM - 1)) ? '0 : mso_tick_q + 1'b1;
      end
      else
      begin
        tick_d = tick_q + 1'b1;
      end
      if (boundary)
      begin
        mso_cyc_d = '0;
        mso_idx_d = (mso_idx_q == IDXW'(MPS - 1)) ? '0 : mso_idx_q + 1'b1;
      end
      else
      begin
        mso_cyc_d = mso_cyc_q + 1'b1;
      end
    end

    since_d = pulse_edge ? '0 : (since_q == '1 ? since_q : since_q + 1'b1);
    if (!sync2_q[2])
    begin
      coupled_d = 1'b0;
    end
    else if (pulse_edge)
    begin
      coupled_d = 1'b1;
    end
    else if (since_q >= SECW'(SEC_CYC + rts_pkg::PULSE_LATE_CYC))
    begin
      coupled_d = 1'b0;
    end
    else
    begin
      coupled_d = coupled_q;
    end

    // A request waits for the next slot start; the start pulse shares that edge.
    tx_start_d = (pend_q || tx_request_in) && boundary;
    pend_d     = (pend_q || tx_request_in) && !boundary;

    stamp_out_d   = receipt_time_stamp_out;
    rx_slot_d     = receipt_slot_out;
    rx_frac_d     = rx_frac_q;
    rx_coupled_d  = rx_coupled_q;
    stamp_valid_d = rx_sync_in;
    if (rx_sync_in)
    begin
      stamp_out_d  = stamp_q;
      rx_slot_d    = mso_idx_q;
      rx_frac_d    = mso_tick_q;
      rx_coupled_d = coupled_q;
    end
  end

  always_comb
  begin
    int_wide = {1'b0, receipt_slot_out} - {1'b0, epoch_q};
    if (receipt_slot_out < epoch_q)
    begin
      int_wide = int_wide + (IDXW + 1)'(MPS);
    end
    int_calc = int_wide[IDXW-1:0];
    pair_ok  = coupled_q && rx_coupled_q && remote_q;

    st_d           = st_q;
    tvalid_d       = tvalid_q;
    tgt_d          = tgt_q;
    type1_d        = type1_q;
    epoch_d        = epoch_q;
    remote_d       = remote_q;
    wr_en          = 1'b0;
    range_strobe_d = 1'b0;
    range_ok_d     = range_ok_out;
    range_int_d    = range_int_out;
    range_frac_d   = range_frac_out;
    case (st_q)
      rts_pkg::RTS_RANGE_IDLE:
      begin
        if (rpt_valid_in)
        begin
          tgt_d    = rpt_target_in;
          type1_d  = rpt_long_type1_in;
          epoch_d  = rpt_epoch_in;
          remote_d = rpt_remote_coupled_in;
          st_d     = rts_pkg::RTS_RANGE_LOOK;
        end
      end
      rts_pkg::RTS_RANGE_LOOK:
      begin
        range_strobe_d = 1'b1;
        range_frac_d   = rx_frac_q;
        if (!pair_ok)
        begin
          tvalid_d[tgt_q] = 1'b0;
          range_ok_d      = 1'b0;
          range_int_d     = mem_rd;
        end
        else if (type1_q)
        begin
          wr_en           = 1'b1;
          tvalid_d[tgt_q] = 1'b1;
          range_ok_d      = 1'b1;
          range_int_d     = int_calc;
        end
        else
        begin
          range_ok_d  = tvalid_q[tgt_q];
          range_int_d = mem_rd;
        end
        st_d = rts_pkg::RTS_RANGE_IDLE;
      end
      default:
      begin
        st_d = rts_pkg::RTS_RANGE_IDLE;
      end
    endcase
    if (!coupled_q)
    begin
      tvalid_d = '0;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      sync1_q                <= '0;
      sync2_q                <= '0;
      pulse_prev_q           <= 1'b0;
      tick_q                 <= '0;
      stamp_q                <= '0;
      mso_tick_q             <= '0;
      mso_cyc_q              <= '0;
      mso_idx_q              <= '0;
      since_q                <= '0;
      coupled_q              <= 1'b0;
      pend_q                 <= 1'b0;
      utc_coupled_out        <= 1'b0;
      tx_start_out           <= 1'b0;
      receipt_time_stamp_out <= '0;
      receipt_slot_out       <= '0;
      rx_frac_q              <= '0;
      rx_coupled_q           <= 1'b0;
      stamp_valid_out        <= 1'b0;
      st_q                   <= rts_pkg::RTS_RANGE_IDLE;
      tvalid_q               <= '0;
      tgt_q                  <= '0;
      type1_q                <= 1'b0;
      epoch_q                <= '0;
      remote_q               <= 1'b0;
      range_strobe_out       <= 1'b0;
      range_ok_out           <= 1'b0;
      range_target_out       <= '0;
      range_int_out          <= '0;
      range_frac_out         <= '0;
    end
    else
    begin
      sync1_q                <= {utc_lock_in, internal_pulse_in, second_pulse_in};
      sync2_q                <= sync1_q;
      pulse_prev_q           <= pulse_sel;
      tick_q                 <= tick_d;
      stamp_q                <= stamp_d;
      mso_tick_q             <= mso_tick_d;
      mso_cyc_q              <= mso_cyc_d;
      mso_idx_q              <= mso_idx_d;
      since_q                <= since_d;
      coupled_q              <= coupled_d;
      pend_q                 <= pend_d;
      utc_coupled_out        <= coupled_d;
      tx_start_out           <= tx_start_d;
      receipt_time_stamp_out <= stamp_out_d;
      receipt_slot_out       <= rx_slot_d;
      rx_frac_q              <= rx_frac_d;
      rx_coupled_q           <= rx_coupled_d;
      stamp_valid_out        <= stamp_valid_d;
      st_q                   <= st_d;
      tvalid_q               <= tvalid_d;
      tgt_q                  <= tgt_d;
      type1_q                <= type1_d;
      epoch_q                <= epoch_d;
      remote_q               <= remote_d;
      range_strobe_out       <= range_strobe_d;
      range_ok_out           <= range_ok_d;
      range_target_out       <= tgt_q;
      range_int_out          <= range_int_d;
      range_frac_out         <= range_frac_d;
    end
  end

endmodule : rts_top

// File: bench/rts_top_chk.sv
// Port-level assertions for the receipt timestamp and range block.
`timescale 1ns/1ps
module rts_top_chk #(
  parameter int SEC_CYC = 2000,
  parameter int MSO_CYC = 500,
  parameter int TARGETS = 16,
  localparam int TPS    = SEC_CYC / rts_pkg::STAMP_CYC,
  localparam int TPM    = MSO_CYC / rts_pkg::STAMP_CYC,
  localparam int MPS    = SEC_CYC / MSO_CYC,
  localparam int TGTW   = $clog2(TARGETS),
  localparam int STW    = $clog2(TPS),
  localparam int FRW    = $clog2(TPM),
  localparam int IDXW   = $clog2(MPS)
) (
  input wire logic            clk_in,
  input wire logic            rst_b_in,
  input wire logic            second_pulse_in,
  input wire logic            internal_pulse_in,
  input wire logic            time_source_ext_in,
  input wire logic            utc_lock_in,
  input wire logic            tx_request_in,
  input wire logic            rx_sync_in,
  input wire logic            rpt_valid_in,
  input wire logic [TGTW-1:0] rpt_target_in,
  input wire logic            rpt_long_type1_in,
  input wire logic [IDXW-1:0] rpt_epoch_in,
  input wire logic            rpt_remote_coupled_in,
  input wire logic            utc_coupled_out,
  input wire logic            tx_start_out,
  input wire logic [STW-1:0]  receipt_time_stamp_out,
  input wire logic [IDXW-1:0] receipt_slot_out,
  input wire logic            stamp_valid_out,
  input wire logic            range_strobe_out,
  input wire logic            range_ok_out,
  input wire logic [TGTW-1:0] range_target_out,
  input wire logic [IDXW-1:0] range_int_out,
  input wire logic [FRW-1:0]  range_frac_out
);
  logic               taken_q, taken_d, pend_q, pend_d;
  logic [TARGETS-1:0] acq_q, acq_d;
  wire logic          take = rpt_valid_in && !taken_q;

  // Acquisition is over-approximated so the type 1 check can only be lenient.
  always_comb
  begin
    taken_d = take;
    pend_d = tx_request_in || (pend_q && !tx_start_out);
    acq_d = acq_q;
    if (take && rpt_long_type1_in)
      acq_d[rpt_target_in] = 1'b1;
  end

  always_ff @(posedge clk_in)
  begin
    taken_q <= rst_b_in && taken_d;
    pend_q <= rst_b_in && pend_d;
    acq_q <= rst_b_in ? acq_d : '0;
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_take; take; endsequence
  sequence s_take1; take && rpt_long_type1_in; endsequence

  a_stamp_follow: assert property (rx_sync_in |=> stamp_valid_out)
    else $error("stamp not updated after receipt");
  a_stamp_span: assert property (stamp_valid_out |-> receipt_time_stamp_out < TPS
    && receipt_slot_out == receipt_time_stamp_out / TPM) else $error("stamp out of second");
  a_range_lat: assert property (s_take |-> ##2 range_strobe_out)
    else $error("range result late");
  a_range_tgt: assert property (s_take |-> ##2 range_target_out == $past(rpt_target_in, 2))
    else $error("range target wrong");
  a_range_frac: assert property (range_strobe_out |-> range_frac_out == receipt_time_stamp_out % TPM)
    else $error("range fraction wrong");
  a_range_int: assert property (s_take1 ##2 range_ok_out |-> range_int_out ==
    (receipt_slot_out + MPS - $past(rpt_epoch_in, 2)) % MPS) else $error("range integer wrong");
  a_remote_lost: assert property (s_take ##0 !rpt_remote_coupled_in |-> ##2 !range_ok_out)
    else $error("range valid with remote uncoupled");
  a_type1_first: assert property (s_take ##0 !rpt_long_type1_in && !acq_q[rpt_target_in]
    |-> ##2 !range_ok_out) else $error("range valid before type 1");
  a_lock_drop: assert property (!utc_lock_in [*5] |-> !utc_coupled_out)
    else $error("coupled flag kept without lock");
  a_tx_asked: assert property (tx_start_out |-> pend_q)
    else $error("transmit start without request");
endmodule : rts_top_chk

bind rts_top rts_top_chk #(.SEC_CYC(SEC_CYC), .MSO_CYC(MSO_CYC), .TARGETS(TARGETS)) u_chk (.*);

// File: bench/rts_sensor.sv
// Behavioural external time sensor: second pulse and UTC lock level.
`timescale 1ns/1ps
module rts_sensor #(
  parameter int SEC_CYC = 2000
) (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic lock_req_in,
  output logic      pulse_out,
  output logic      lock_out
);
  int cnt_q;

  // The sensor keeps its own second, unrelated in phase to the device.
  always_ff @(posedge clk_in)
  begin
    cnt_q <= (!rst_b_in || cnt_q == SEC_CYC - 1) ? 0 : cnt_q + 1;
    pulse_out <= rst_b_in && cnt_q > 40 && cnt_q < 49;
    lock_out <= lock_req_in;
  end
endmodule : rts_sensor

// File: bench/rts_top_tb_top.sv
// Self-checking bench: stamps, ranges, slot-aligned transmit and coupling.
`timescale 1ns/1ps
module rts_top_tb_top;
  localparam int SC = 2000;
  localparam int MC = 500;
  logic       clk_in, pulse, lock, cpl_o, txs_o, sv_o, rs_o, ok_o, okx, rc;
  logic       rst_b_in = 1'b0, tsel = 1'b1, lock_req = 1'b1, tx_req = 1'b0, rx_sync = 1'b0;
  logic       rpt_v = 1'b0, rpt_t1 = 1'b0, rpt_rc = 1'b0;
  logic [3:0] rpt_tgt = 4'h0, tgt_o;
  logic [1:0] rpt_ep = 2'h0, slot_o, int_o, t, sto[4];
  logic [6:0] stamp_o;
  logic [4:0] frac_o;
  logic [8:0] sq[$], rq[$], e;
  logic [31:0] rnd = 32'h3b30_92da;
  bit         acq[4];
  int         bad_count = 0, n_tests = 0, cyc = 0, p0 = 0, ntx = 0, k;

  // Each source pin only pulses while selected, so a swapped selection loses coupling.
  rts_top #(.SEC_CYC(SC), .MSO_CYC(MC)) dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .second_pulse_in(pulse && tsel),
    .internal_pulse_in(pulse && !tsel), .time_source_ext_in(tsel), .utc_lock_in(lock),
    .tx_request_in(tx_req), .rx_sync_in(rx_sync), .rpt_valid_in(rpt_v),
    .rpt_target_in(rpt_tgt), .rpt_long_type1_in(rpt_t1), .rpt_epoch_in(rpt_ep),
    .rpt_remote_coupled_in(rpt_rc), .utc_coupled_out(cpl_o), .tx_start_out(txs_o),
    .receipt_time_stamp_out(stamp_o), .receipt_slot_out(slot_o), .stamp_valid_out(sv_o),
    .range_strobe_out(rs_o), .range_ok_out(ok_o), .range_target_out(tgt_o),
    .range_int_out(int_o), .range_frac_out(frac_o));

  rts_sensor #(.SEC_CYC(SC)) u_sensor (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .lock_req_in(lock_req), .pulse_out(pulse), .lock_out(lock));

  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction : lfsr

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize;
    if (bad_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  // Waits for a fresh rising edge of the sensor pulse; p0 tracks the restart.
  task automatic wait_pulse;
    int n;
    n = 0;
    while (pulse !== 1'b0 && n < 3 * SC)
    begin
      @(posedge clk_in);
      n++;
    end
    while (pulse !== 1'b1 && n < 3 * SC)
    begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 3 * SC)
    begin
      bad_count++;
      summarize();
    end
    else
    begin
      p0 = cyc + 2;
    end
  endtask : wait_pulse

  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (sv_o === 1'b1)
    begin
      e = sq.size() > 0 ? sq.pop_front() : 9'h1ff;
      check({slot_o, stamp_o}, e);
    end
    if (rs_o === 1'b1)
    begin
      e = rq.size() > 0 ? rq.pop_front() : 9'h1ff;
      check({1'b0, ok_o, ok_o ? int_o : 2'b00, frac_o}, e);
      check({5'h00, tgt_o}, {5'h00, rpt_tgt});
    end
    if (txs_o === 1'b1)
    begin
      ntx <= ntx + 1;
      check(9'((cyc - p0) % MC < rts_pkg::TX_ALIGN_CYC), 9'h001);
    end
  end

  initial
  begin
    repeat (4) @(posedge clk_in);
    rst_b_in <= 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      repeat (16) rnd = lfsr(rnd);
      k = rnd[6:0] % 80;
      if (i == 10)
        lock_req <= 1'b0;
      if (i == 12)
        lock_req <= 1'b1;
      tsel <= rnd[7];
      wait_pulse();
      repeat (25 * k + 14) @(posedge clk_in);
      check({8'h00, cpl_o}, {8'h00, lock_req});
      rx_sync <= 1'b1;
      tx_req <= 1'b1;
      sq.push_back({2'(k / 20), 7'(k)});
      @(posedge clk_in);
      rx_sync <= 1'b0;
      tx_req <= 1'b0;
      @(posedge clk_in);
      t = rnd[9:8];
      rc = !(i == 5 || i == 9);
      rpt_v <= 1'b1;
      rpt_tgt <= {2'b00, t};
      rpt_t1 <= (i == 1) || (i != 0 && rnd[10]);
      rpt_rc <= rc;
      rpt_ep <= rnd[15:14];
      if (!lock_req)
        acq = '{default: 1'b0};
      if (lock_req && rc && ((i == 1) || (i != 0 && rnd[10])))
      begin
        acq[t] = 1'b1;
        sto[t] = 2'(k / 20 - rnd[15:14]);
      end
      else if (!rc)
        acq[t] = 1'b0;
      okx = lock_req && rc && acq[t];
      rq.push_back({1'b0, okx, okx ? sto[t] : 2'b00, 5'(k % 20)});
      @(posedge clk_in);
      rpt_v <= 1'b0;
      repeat (3) @(posedge clk_in);
    end
    repeat (MC + 20) @(posedge clk_in);
    check(9'(ntx), 9'd16);
    check(9'(sq.size() + rq.size()), 9'h000);
    summarize();
  end
endmodule : rts_top_tb_top
